// file: hdl/scl_pkg.sv
// speed command limiter: shared constants, types and helpers
// assumes frequencies in 0.01 Hz units, analog percent in 0.01 % units

package scl_pkg;

    // ************************************************
    // widths and scales
    // ************************************************
    localparam int FREQ_W = 15;
    localparam int PCT_W = 16;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 15'h7530;
    localparam logic [13:0] PCT_FULL = 14'h2710;
    localparam logic [28:0] PCT_DIV = 29'h0002710;
    localparam int STAGES = 16;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [FREQ_W-1:0] FLOOR_DEFAULT = 15'h0000;
    localparam logic [FREQ_W-1:0] CEIL_DEFAULT = 15'h1770;
    localparam logic [FREQ_W-1:0] CEIL_DEFAULT_ALT = 15'h1388;
    localparam logic [FREQ_W-1:0] LOWEST_DEFAULT = 15'h0000;
    localparam logic POLICY_DEFAULT = 1'b0;
    localparam logic [FREQ_W-1:0] JOG_DEFAULT = 15'h0258;
    localparam logic [STAGES-1:0][FREQ_W-1:0] STAGE_DEFAULTS = {
        15'h0000, 15'h0000, 15'h0000, 15'h0000,
        15'h0000, 15'h0000, 15'h0000, 15'h0000,
        15'h1388, 15'h0fa0, 15'h0bb8, 15'h07d0,
        15'h05dc, 15'h03e8, 15'h01f4, 15'h01f4};

    // ************************************************
    // modes
    // ************************************************
    typedef enum logic [1:0] {
        DIR_BOTH = 2'b00,
        DIR_FWD_ONLY = 2'b01,
        DIR_REV_ONLY = 2'b10,
        DIR_NEG_BIAS = 2'b11
    } scl_dir_e;

    typedef enum logic [3:0] {
        SRC_PANEL = 4'h0,
        SRC_PANEL_VR = 4'h1,
        SRC_AIN_A = 4'h2,
        SRC_AIN_B = 4'h3,
        SRC_SUM = 4'h4,
        SRC_MAX = 4'h5,
        SRC_MIN = 4'h6,
        SRC_PID = 4'h7,
        SRC_UPDOWN = 4'h8
    } scl_src_e;

    localparam scl_dir_e DIR_DEFAULT = DIR_FWD_ONLY;
    localparam scl_src_e SRC_DEFAULT = SRC_PANEL_VR;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        scl_dir_e direction_restrict_select;
        logic [FREQ_W-1:0] freq_floor;
        logic [FREQ_W-1:0] freq_ceiling;
        logic [FREQ_W-1:0] lowest_output_freq;
        logic min_output_policy;
        scl_src_e freq_source_select;
        logic [FREQ_W-1:0] jog_speed;
    } scl_cfg_s;

    typedef struct packed {
        logic [FREQ_W-1:0] freq;
        logic rev;
    } scl_cmd_s;

    function automatic logic [FREQ_W-1:0] scl_sat(input logic [FREQ_W-1:0] v);
        scl_sat = (v > FREQ_MAX) ? FREQ_MAX : v;
    endfunction : scl_sat

endpackage : scl_pkg

// file: hdl/scl_scaler.sv
// linear mapping of a percent magnitude onto the floor..ceiling span
// assumes magnitude already clipped to full scale

`timescale 1ns/100ps
`default_nettype none

module scl_scaler
(
    // percent magnitude
    input wire logic [13:0] mag_i,
    // limits
    input wire logic [scl_pkg::FREQ_W-1:0] floor_i,
    input wire logic [scl_pkg::FREQ_W-1:0] ceiling_i,
    // result
    output logic [scl_pkg::FREQ_W-1:0] freq_o
);

    logic [scl_pkg::FREQ_W-1:0] span;
    logic [28:0] prod;
    logic [28:0] quot;

    always_comb
    begin
        // an inverted pair gives a flat floor rather than wrapping
        span = (ceiling_i >= floor_i) ? 15'(ceiling_i - floor_i) : 15'h0000;
        prod = 29'(span) * 29'(mag_i);
        quot = prod / scl_pkg::PCT_DIV;
        freq_o = 15'(floor_i + quot[14:0]);
    end

endmodule : scl_scaler

`default_nettype wire

// file: hdl/scl_stage_table.sv
// table of sixteen preset speeds, entry 0 being the master speed
// assumes writes come as single-cycle strobes from the configuring side

`timescale 1ns/100ps
`default_nettype none

module scl_stage_table
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_idx_i,
    input wire logic [scl_pkg::FREQ_W-1:0] wr_val_i,
    // read port
    input wire logic [3:0] rd_idx_i,
    output logic [scl_pkg::FREQ_W-1:0] rd_val_o
);

    typedef struct packed {
        logic [scl_pkg::STAGES-1:0][scl_pkg::FREQ_W-1:0] spd;
    } scl_tbl_s;

    scl_tbl_s st_r;
    scl_tbl_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (wr_en_i)
        begin
            st_nxt.spd[wr_idx_i] = scl_pkg::scl_sat(wr_val_i);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r.spd <= scl_pkg::STAGE_DEFAULTS;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rd_val_o = st_r.spd[rd_idx_i];

endmodule : scl_stage_table

`default_nettype wire

// file: hdl/scl_top.sv
// speed command limiter: resolves, scales, limits and restricts the
// frequency command handed to the output generator
// assumes all inputs synchronous to clk_sys_i; one cycle of latency

`timescale 1ns/100ps
`default_nettype none

module scl_top
#(
    parameter bit REGION_ALT = 1'b0
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // configuration load
    input wire logic cfg_we_i,
    input wire scl_pkg::scl_cfg_s cfg_i,
    output scl_pkg::scl_cfg_s cfg_o,
    // preset table load
    input wire logic stage_we_i,
    input wire logic [3:0] stage_idx_i,
    input wire logic [scl_pkg::FREQ_W-1:0] stage_val_i,
    // run and direction request
    input wire logic run_i,
    input wire logic dir_rev_i,
    // auto operation
    input wire logic auto_active_i,
    input wire scl_pkg::scl_cmd_s auto_cmd_i,
    // jog
    input wire logic jog_i,
    // multi-function terminals, one while the contact is closed
    input wire logic ain_enable_i,
    input wire logic [3:0] stage_sel_i,
    // command sources
    input wire logic signed [scl_pkg::PCT_W-1:0] panel_vr_i,
    input wire logic signed [scl_pkg::PCT_W-1:0] analog_in_a_i,
    input wire logic signed [scl_pkg::PCT_W-1:0] analog_in_b_i,
    input wire logic signed [scl_pkg::PCT_W-1:0] pid_pct_i,
    input wire logic [scl_pkg::FREQ_W-1:0] updown_freq_i,
    // result to the output generator
    output scl_pkg::scl_cmd_s cmd_o,
    output logic forbidden_o
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        scl_pkg::scl_cfg_s cfg;
        scl_pkg::scl_cmd_s cmd;
        logic forbidden;
    } scl_state_s;

    scl_state_s st_r;
    scl_state_s st_nxt;

    logic [3:0] tbl_idx;
    logic [scl_pkg::FREQ_W-1:0] tbl_val;
    logic [13:0] pct_mag;
    logic pct_neg;
    logic [scl_pkg::FREQ_W-1:0] scaled;

    // ************************************************
    // preset table and scaler
    // ************************************************
    // the table is shared: an active stage code reads its stage,
    // otherwise the master speed is read for the panel source
    assign tbl_idx = stage_sel_i;

    scl_stage_table u_table
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_en_i(stage_we_i),
        .wr_idx_i(stage_idx_i),
        .wr_val_i(stage_val_i),
        .rd_idx_i(tbl_idx),
        .rd_val_o(tbl_val)
    );

    // limits come from the registered configuration, never from cfg_i
    scl_scaler u_scaler
    (
        .mag_i(pct_mag),
        .floor_i(st_r.cfg.freq_floor),
        .ceiling_i(st_r.cfg.freq_ceiling),
        .freq_o(scaled)
    );

    // ************************************************
    // analog percent selection
    // ************************************************
    always_comb
    begin
        logic signed [16:0] pct;
        logic signed [16:0] abs_pct;
        logic allow_neg;
        pct = 17'sh00000;
        abs_pct = 17'sh00000;
        allow_neg = (st_r.cfg.direction_restrict_select == scl_pkg::DIR_NEG_BIAS);
        if (ain_enable_i)
        begin
            pct = 17'(analog_in_a_i);
        end
        else
        begin
            unique case (st_r.cfg.freq_source_select)
                scl_pkg::SRC_PANEL_VR: pct = 17'(panel_vr_i);
                scl_pkg::SRC_AIN_A: pct = 17'(analog_in_a_i);
                scl_pkg::SRC_AIN_B: pct = 17'(analog_in_b_i);
                // signed addition of the two inputs
                scl_pkg::SRC_SUM: pct = 17'(analog_in_a_i) + 17'(analog_in_b_i);
                scl_pkg::SRC_MAX:
                    pct = (analog_in_a_i > analog_in_b_i) ? 17'(analog_in_a_i)
                                                          : 17'(analog_in_b_i);
                scl_pkg::SRC_MIN:
                    pct = (analog_in_a_i < analog_in_b_i) ? 17'(analog_in_a_i)
                                                          : 17'(analog_in_b_i);
                scl_pkg::SRC_PID: pct = 17'(pid_pct_i);
                default: pct = 17'sh00000;
            endcase
        end
        // negative band reverses only under the bias setting
        pct_neg = allow_neg && (pct < 17'sh00000);
        if (pct_neg)
        begin
            abs_pct = -pct;
        end
        else if (pct < 17'sh00000)
        begin
            abs_pct = 17'sh00000;
        end
        else
        begin
            abs_pct = pct;
        end
        if (abs_pct > 17'(scl_pkg::PCT_FULL))
        begin
            pct_mag = scl_pkg::PCT_FULL;
        end
        else
        begin
            pct_mag = abs_pct[13:0];
        end
    end

    // ************************************************
    // resolve, limit and restrict
    // ************************************************
    always_comb
    begin
        logic [scl_pkg::FREQ_W-1:0] f;
        logic rev;
        logic fwd_bad;
        logic rev_bad;
        logic [scl_pkg::FREQ_W-1:0] fl;
        logic [scl_pkg::FREQ_W-1:0] cl;
        logic [scl_pkg::FREQ_W-1:0] lo;
        f = 15'h0000;
        rev = dir_rev_i;
        fwd_bad = 1'b0;
        rev_bad = 1'b0;
        fl = st_r.cfg.freq_floor;
        cl = st_r.cfg.freq_ceiling;
        lo = st_r.cfg.lowest_output_freq;
        st_nxt = st_r;

        if (cfg_we_i)
        begin
            st_nxt.cfg = cfg_i;
            st_nxt.cfg.freq_floor = scl_pkg::scl_sat(cfg_i.freq_floor);
            st_nxt.cfg.freq_ceiling = scl_pkg::scl_sat(cfg_i.freq_ceiling);
            st_nxt.cfg.lowest_output_freq = scl_pkg::scl_sat(cfg_i.lowest_output_freq);
            st_nxt.cfg.jog_speed = scl_pkg::scl_sat(cfg_i.jog_speed);
            // an unused source code falls back to the master speed
            if (cfg_i.freq_source_select > scl_pkg::SRC_UPDOWN)
            begin
                st_nxt.cfg.freq_source_select = scl_pkg::SRC_PANEL;
            end
        end

        // priority of command sources
        if (auto_active_i)
        begin
            f = auto_cmd_i.freq;
            rev = auto_cmd_i.rev;
        end
        else if (jog_i)
        begin
            f = st_r.cfg.jog_speed;
        end
        else if (ain_enable_i)
        begin
            f = scaled;
            rev = dir_rev_i ^ pct_neg;
        end
        else if (stage_sel_i != 4'h0)
        begin
            f = tbl_val;
        end
        else
        begin
            unique case (st_r.cfg.freq_source_select)
                scl_pkg::SRC_PANEL: f = tbl_val;
                scl_pkg::SRC_UPDOWN: f = updown_freq_i;
                default:
                begin
                    f = scaled;
                    rev = dir_rev_i ^ pct_neg;
                end
            endcase
        end

        // minimum output policy
        if ((fl < lo) && (f < lo))
        begin
            if (st_r.cfg.min_output_policy)
            begin
                f = lo;
            end
            else
            begin
                f = 15'h0000;
            end
        end
        else if (f < fl)
        begin
            f = fl;
        end
        // ceiling last, so an inverted pair can never exceed it
        if (f > cl)
        begin
            f = cl;
        end

        // forbidden direction is zeroed, never turned round
        fwd_bad = (st_r.cfg.direction_restrict_select == scl_pkg::DIR_REV_ONLY) && !rev;
        rev_bad = (st_r.cfg.direction_restrict_select == scl_pkg::DIR_FWD_ONLY) && rev;
        // the refused direction stays on cmd rev for the generator to see
        st_nxt.forbidden = run_i && (fwd_bad || rev_bad);
        if (!run_i || fwd_bad || rev_bad)
        begin
            f = 15'h0000;
        end
        st_nxt.cmd.freq = f;
        st_nxt.cmd.rev = rev;
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r.cfg.direction_restrict_select <= scl_pkg::DIR_DEFAULT;
            st_r.cfg.freq_floor <= scl_pkg::FLOOR_DEFAULT;
            st_r.cfg.freq_ceiling <= REGION_ALT ? scl_pkg::CEIL_DEFAULT_ALT
                                                : scl_pkg::CEIL_DEFAULT;
            st_r.cfg.lowest_output_freq <= scl_pkg::LOWEST_DEFAULT;
            st_r.cfg.min_output_policy <= scl_pkg::POLICY_DEFAULT;
            st_r.cfg.freq_source_select <= scl_pkg::SRC_DEFAULT;
            st_r.cfg.jog_speed <= scl_pkg::JOG_DEFAULT;
            // the generator sees a stopped command until the first edge
            st_r.cmd <= '0;
            st_r.forbidden <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign cfg_o = st_r.cfg;
    assign cmd_o = st_r.cmd;
    assign forbidden_o = st_r.forbidden;

endmodule : scl_top

`default_nettype wire

// file: verification/scl_top_sva.sv
// checker watching the ports of the speed command limiter top
// assumes one clock domain and the active high asynchronous reset
`timescale 1ns/100ps
`default_nettype none

module scl_top_sva
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // watched ports
    input wire logic cfg_we_i,
    input wire scl_pkg::scl_cfg_s cfg_i,
    input wire scl_pkg::scl_cfg_s cfg_o,
    input wire logic run_i,
    input wire logic auto_active_i,
    input wire scl_pkg::scl_cmd_s auto_cmd_i,
    input wire scl_pkg::scl_cmd_s cmd_o,
    input wire logic forbidden_o
);
    // ************************************************
    // properties
    // ************************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    stop_zero_a: assert property (!run_i |=> cmd_o.freq == 15'h0000 && !forbidden_o)
        else $error("frequency not zero while stopped");
    forbid_zero_a: assert property (forbidden_o |-> cmd_o.freq == 15'h0000)
        else $error("forbidden direction still driven");
    forbid_dir_a: assert property (forbidden_o == ($past(run_i) &&
        (($past(cfg_o.direction_restrict_select) == scl_pkg::DIR_FWD_ONLY && cmd_o.rev) ||
        ($past(cfg_o.direction_restrict_select) == scl_pkg::DIR_REV_ONLY && !cmd_o.rev))))
        else $error("forbidden flag wrong");
    ceil_clamp_a: assert property (cmd_o.freq <= $past(cfg_o.freq_ceiling))
        else $error("frequency above ceiling");
    floor_hold_a: assert property (run_i && cfg_o.freq_floor >= cfg_o.lowest_output_freq &&
        cfg_o.freq_ceiling >= cfg_o.freq_floor |=> forbidden_o || cmd_o.freq >= $past(cfg_o.freq_floor))
        else $error("frequency below floor");
    lowest_lift_a: assert property (run_i && cfg_o.min_output_policy &&
        cfg_o.freq_ceiling >= cfg_o.lowest_output_freq && cfg_o.freq_ceiling >= cfg_o.freq_floor
        |=> forbidden_o || cmd_o.freq >= $past(cfg_o.lowest_output_freq))
        else $error("frequency below lowest output");
    zero_band_a: assert property (run_i && !cfg_o.min_output_policy &&
        cfg_o.freq_floor < cfg_o.lowest_output_freq && cfg_o.freq_ceiling >= cfg_o.lowest_output_freq
        |=> cmd_o.freq == 15'h0000 || cmd_o.freq >= $past(cfg_o.lowest_output_freq))
        else $error("frequency inside the zero band");
    auto_dir_a: assert property (run_i && auto_active_i |=> cmd_o.rev == $past(auto_cmd_i.rev))
        else $error("auto direction not followed");
    dir_load_a: assert property (cfg_we_i |=>
        cfg_o.direction_restrict_select == $past(cfg_i.direction_restrict_select))
        else $error("restriction not loaded");
endmodule : scl_top_sva

bind scl_top scl_top_sva chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_we_i(cfg_we_i),
    .cfg_i(cfg_i), .cfg_o(cfg_o), .run_i(run_i), .auto_active_i(auto_active_i),
    .auto_cmd_i(auto_cmd_i), .cmd_o(cmd_o), .forbidden_o(forbidden_o));
`default_nettype wire

// file: verification/scl_drive_model.sv
// far side model: terminal contacts and the output frequency generator
// assumes contacts come as closed flags and the command from scl_top
`timescale 1ns/100ps
`default_nettype none

module scl_drive_model
(
    // clock
    input wire logic clk_sys_i,
    // terminal contacts, one while closed
    input wire logic [3:0] contact_closed_i,
    output logic [3:0] stage_sel_o,
    // command to the generator
    input wire scl_pkg::scl_cmd_s cmd_i,
    output scl_pkg::scl_cmd_s gen_cmd_o
);
    // ************************************************
    // terminals and generator
    // ************************************************
    assign stage_sel_o = contact_closed_i;
    always_ff @(posedge clk_sys_i)
        gen_cmd_o <= cmd_i;
endmodule : scl_drive_model
`default_nettype wire

// file: verification/test_scl_top.sv
// self-checking bench for the speed command limiter
// assumes scl_pkg, the design, the model and the checker compiled first
`timescale 1ns/100ps
`default_nettype none

module test_scl_top;
    // ************************************************
    // signals
    // ************************************************
    localparam logic [14:0] STG [16] = '{15'h01f4, 15'h01f4, 15'h03e8, 15'h05dc, 15'h07d0,
        15'h0bb8, 15'h0fa0, 15'h1388, 15'h0, 15'h0, 15'h0, 15'h0, 15'h0, 15'h0, 15'h0, 15'h0};
    localparam logic [14:0] SRCX [9] = '{15'h03e8, 15'h0578, 15'h0708, 15'h0a28, 15'h0d48,
        15'h0a28, 15'h0708, 15'h0bb8, 15'h08ae};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cfg_we_i = 1'b0;
    scl_pkg::scl_cfg_s cfg_i = '0;
    scl_pkg::scl_cfg_s cfg_o;
    logic stage_we_i = 1'b0;
    logic [3:0] stage_idx_i = 4'h0;
    logic [14:0] stage_val_i = 15'h0000;
    logic run_i = 1'b0;
    logic dir_rev_i = 1'b0;
    logic auto_active_i = 1'b0;
    scl_pkg::scl_cmd_s auto_cmd_i = '0;
    logic jog_i = 1'b0;
    logic ain_enable_i = 1'b0;
    logic [3:0] contacts = 4'h0;
    logic [3:0] stage_sel_i;
    logic signed [15:0] panel_vr_i = 16'h03e8;
    logic signed [15:0] ain_a = 16'h07d0;
    logic signed [15:0] ain_b = 16'h0fa0;
    logic signed [15:0] pid_pct_i = 16'h1388;
    logic [14:0] updown_freq_i = 15'h08ae;
    scl_pkg::scl_cmd_s cmd_o;
    logic forbidden_o;
    int fails = 0;
    int samples_checked = 0;

    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    scl_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_we_i(cfg_we_i), .cfg_i(cfg_i),
        .cfg_o(cfg_o), .stage_we_i(stage_we_i), .stage_idx_i(stage_idx_i),
        .stage_val_i(stage_val_i), .run_i(run_i), .dir_rev_i(dir_rev_i),
        .auto_active_i(auto_active_i), .auto_cmd_i(auto_cmd_i), .jog_i(jog_i),
        .ain_enable_i(ain_enable_i), .stage_sel_i(stage_sel_i), .panel_vr_i(panel_vr_i),
        .analog_in_a_i(ain_a), .analog_in_b_i(ain_b), .pid_pct_i(pid_pct_i),
        .updown_freq_i(updown_freq_i), .cmd_o(cmd_o), .forbidden_o(forbidden_o));
    scl_drive_model drv (.clk_sys_i(clk_sys_i), .contact_closed_i(contacts),
        .stage_sel_o(stage_sel_i), .cmd_i(cmd_o), .gen_cmd_o());

    // ************************************************
    // helpers
    // ************************************************
    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic note(input logic bad, input logic [79:0] got, input logic [79:0] exp);
        samples_checked++;
        if (bad)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : note
    task automatic cmp_f(input logic [14:0] got, input logic [14:0] exp);
        note(got !== exp, 80'(got), 80'(exp));
    endtask : cmp_f
    task automatic cmp_b(input logic got, input logic exp);
        note(got !== exp, 80'(got), 80'(exp));
    endtask : cmp_b
    task automatic cmp_c(input scl_pkg::scl_cfg_s got, input scl_pkg::scl_cfg_s exp);
        note(got !== exp, 80'(got), 80'(exp));
    endtask : cmp_c
    // ceiling is always kept at or above the floor
    task automatic setcfg(input scl_pkg::scl_dir_e d, input logic [14:0] fl,
        input logic [14:0] ce, input logic [14:0] lo, input logic pol, input scl_pkg::scl_src_e s);
        cfg_i = '{d, fl, ce, lo, pol, s, 15'h0258};
        cfg_we_i = 1'b1;
        tick();
        cfg_we_i = 1'b0;
    endtask : setcfg
    task automatic step(input logic [14:0] f, input logic rv, input logic fb);
        tick();
        cmp_f(cmd_o.freq, f);
        cmp_b(cmd_o.rev, rv);
        cmp_b(forbidden_o, fb);
    endtask : step

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset;
        scl_pkg::scl_cfg_s d;
        d = '{scl_pkg::DIR_FWD_ONLY, 15'h0, 15'h1770, 15'h0, 1'b0, scl_pkg::SRC_PANEL_VR, 15'h0258};
        cmp_c(cfg_o, d);
        cmp_f(cmd_o.freq, 15'h0000);
    endtask : t_reset
    task automatic t_stages;
        for (int i = 1; i < 16; i++)
        begin
            contacts = 4'(i);
            step(STG[i], 1'b0, 1'b0);
        end
        stage_we_i = 1'b1;
        stage_idx_i = 4'he;
        stage_val_i = 15'h1b58;
        tick();
        stage_idx_i = 4'hf;
        stage_val_i = 15'h0bb8;
        tick();
        stage_we_i = 1'b0;
        contacts = 4'he;
        step(15'h1770, 1'b0, 1'b0);
        contacts = 4'hf;
        step(15'h0bb8, 1'b0, 1'b0);
        contacts = 4'h0;
        setcfg(scl_pkg::DIR_FWD_ONLY, 15'h0, 15'h1770, 15'h0, 1'b0, scl_pkg::SRC_PANEL);
        step(15'h01f4, 1'b0, 1'b0);
    endtask : t_stages
    task automatic t_sources;
        for (int s = 0; s < 9; s++)
        begin
            setcfg(scl_pkg::DIR_BOTH, 15'h03e8, 15'h1388, 15'h0, 1'b0, scl_pkg::scl_src_e'(4'(s)));
            step(SRCX[s], 1'b0, 1'b0);
        end
        setcfg(scl_pkg::DIR_BOTH, 15'h03e8, 15'h1388, 15'h0, 1'b0, scl_pkg::SRC_AIN_A);
        ain_a = 16'h0000;
        step(15'h03e8, 1'b0, 1'b0);
        ain_a = 16'h2ee0;
        step(15'h1388, 1'b0, 1'b0);
    endtask : t_sources
    task automatic t_direction;
        logic fb;
        ain_a = 16'h07d0;
        for (int d = 0; d < 4; d++)
        begin
            for (int r = 0; r < 2; r++)
            begin
                setcfg(scl_pkg::scl_dir_e'(2'(d)), 15'h03e8, 15'h1388, 15'h0, 1'b0, scl_pkg::SRC_AIN_A);
                dir_rev_i = 1'(r);
                fb = (d == 1 && r == 1) || (d == 2 && r == 0);
                step(fb ? 15'h0 : 15'h0708, 1'(r), fb);
            end
        end
        dir_rev_i = 1'b0;
        ain_a = 16'he890;
        setcfg(scl_pkg::DIR_NEG_BIAS, 15'h03e8, 15'h1388, 15'h0, 1'b0, scl_pkg::SRC_SUM);
        step(15'h0708, 1'b1, 1'b0);
        pid_pct_i = 16'hec78;
        setcfg(scl_pkg::DIR_NEG_BIAS, 15'h03e8, 15'h1388, 15'h0, 1'b0, scl_pkg::SRC_PID);
        step(15'h0bb8, 1'b1, 1'b0);
        setcfg(scl_pkg::DIR_FWD_ONLY, 15'h03e8, 15'h1388, 15'h0, 1'b0, scl_pkg::SRC_PID);
        step(15'h03e8, 1'b0, 1'b0);
    endtask : t_direction
    task automatic t_policy;
        updown_freq_i = 15'h01f4;
        setcfg(scl_pkg::DIR_BOTH, 15'h0, 15'h1770, 15'h03e8, 1'b0, scl_pkg::SRC_UPDOWN);
        step(15'h0000, 1'b0, 1'b0);
        setcfg(scl_pkg::DIR_BOTH, 15'h0, 15'h1770, 15'h03e8, 1'b1, scl_pkg::SRC_UPDOWN);
        step(15'h03e8, 1'b0, 1'b0);
        setcfg(scl_pkg::DIR_BOTH, 15'h04b0, 15'h1770, 15'h03e8, 1'b0, scl_pkg::SRC_UPDOWN);
        step(15'h04b0, 1'b0, 1'b0);
        run_i = 1'b0;
        step(15'h0000, 1'b0, 1'b0);
        run_i = 1'b1;
    endtask : t_policy
    task automatic t_priority;
        updown_freq_i = 15'h08ae;
        ain_a = 16'h1388;
        setcfg(scl_pkg::DIR_BOTH, 15'h0, 15'h1770, 15'h0, 1'b0, scl_pkg::SRC_UPDOWN);
        auto_cmd_i = '{15'h0fa0, 1'b1};
        auto_active_i = 1'b1;
        jog_i = 1'b1;
        ain_enable_i = 1'b1;
        contacts = 4'h3;
        step(15'h0fa0, 1'b1, 1'b0);
        auto_active_i = 1'b0;
        step(15'h0258, 1'b0, 1'b0);
        jog_i = 1'b0;
        step(15'h0bb8, 1'b0, 1'b0);
        ain_enable_i = 1'b0;
        step(15'h05dc, 1'b0, 1'b0);
        contacts = 4'h0;
        step(15'h08ae, 1'b0, 1'b0);
        setcfg(scl_pkg::DIR_BOTH, 15'h0, 15'h7fff, 15'h0, 1'b0, scl_pkg::scl_src_e'(4'hf));
        cmp_f(cfg_o.freq_ceiling, 15'h7530);
        step(15'h01f4, 1'b0, 1'b0);
    endtask : t_priority

    // ************************************************
    // sequence and verdict
    // ************************************************
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        run_i = 1'b1;
        t_stages();
        t_sources();
        t_direction();
        t_policy();
        t_priority();
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        tally_and_finish();
    end
endmodule : test_scl_top
`default_nettype wire
